// ==== core/adc_ctl_pkg.sv ====
// constants for the converter clock and start control block
package adc_ctl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DIV    = 8'h04;
	localparam logic [7:0] OFS_STIME  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// control register fields
	localparam int CTRL_REFSEL_BIT = 0;
	localparam int CTRL_START_BIT  = 1;
	// status register fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_SAMPLE_BIT = 1;
	localparam int STAT_REFSEL_BIT = 2;
	// reset values
	localparam logic [7:0] DIV_RST   = 8'h00;
	localparam logic [7:0] STIME_RST = 8'h02;
	// divider: converter clock period is 4*(1+div) system clocks
	localparam int DIV_MULT = 4;
	localparam int CNT_W    = 10;
	// converter cycles spent converting after sampling ends
	localparam logic [7:0] CONV_CYCLES = 8'h0A;
	// system clock figures
	localparam int SYS_CLK_NS = 40;
	localparam int SYS_CLK_HZ = 25_000_000;
	// converter clock limits the user logic must honour
	localparam int CONV_CLK_MIN_HZ = 500_000;
	localparam int CONV_CLK_MAX_HZ = 10_000_000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONV   = 2'b11
	} conv_state_t;
endpackage

// ==== core/adc_clock_and_start_control.sv ====
// converter clock divider, start and sample time control with apb access
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
// What this block does
// - reference select 0 picks the internal 2.56 V source, 1 the external.
// - converter clock period is 4*(1+divider value) system clock periods.
// - every control input is sampled on the system clock edge.
// - a start seen high at a rising edge while idle begins a conversion.
// - the converter clock stays internal and is never a port.
// - the sampling output is high during acquisition, low when it ends.
module adc_clock_and_start_control
#(
	// divider and sample-time field widths; the prescaler counter is
	// sized for an 8-bit divider
	parameter int DIV_W   = 8,
	parameter int STIME_W = 8
)
(
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// converter side
	output logic             REF_INTERNAL_EN,
	output logic             SAMPLING,
	output logic             BUSY,
	output logic             CONV_DONE
);
	// register map, one word each, data in the low bits:
	//   control  bit0 reference select, bit1 write 1 to start
	//   divider  converter clock divider, period 4*(1+value) clocks
	//   sample   sample length in converter clocks, minus one
	//   status   bit0 busy, bit1 sampling, bit2 reference select
	// a start written while busy is dropped without an error; divider
	// and sample length are frozen at the start, so a late write only
	// counts for the next conversion

	typedef struct packed
	{
		// settings written by the user logic
		logic                          ref_sel;
		logic [DIV_W-1:0]              div;
		logic [STIME_W-1:0]            stime;
		// copies frozen for the conversion in flight
		logic [DIV_W-1:0]              run_div;
		logic [STIME_W-1:0]            run_stime;
		// converter clock prescaler
		logic [adc_ctl_pkg::CNT_W-1:0] pre_cnt;
		logic                          tick;
		// conversion sequencing
		logic [STIME_W-1:0]            cyc_cnt;
		adc_ctl_pkg::conv_state_t      state;
		logic                          done;
		// apb answer
		logic [31:0]                   rdata;
		logic                          ready;
		logic                          slverr;
		// converter side outputs, kept in flops
		logic                          ref_int;
		logic                          samp;
		logic                          busy;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// last converter clock of a conversion
	localparam logic [STIME_W-1:0] conv_last =
		STIME_W'(adc_ctl_pkg::CONV_CYCLES - 8'h01);

	// converter clock period in system clocks, minus one; for the top
	// divider value the product wraps to zero and the minus one still
	// lands on the right count
	function automatic logic [adc_ctl_pkg::CNT_W-1:0] div_top
	(
		input logic [DIV_W-1:0] d
	);
		logic [adc_ctl_pkg::CNT_W-1:0] p;
		p = adc_ctl_pkg::CNT_W'(adc_ctl_pkg::DIV_MULT)
			* (adc_ctl_pkg::CNT_W'(d) + adc_ctl_pkg::CNT_W'(1));
		div_top = p - adc_ctl_pkg::CNT_W'(1);
	endfunction

	// one converter clock further in a sample or conversion count
	function automatic logic [STIME_W-1:0] cyc_step
	(
		input logic [STIME_W-1:0] c
	);
		cyc_step = c + STIME_W'(1);
	endfunction

	// a count is finished once it has reached its last value
	function automatic logic reached
	(
		input logic [STIME_W-1:0] c,
		input logic [STIME_W-1:0] last
	);
		reached = (c >= last);
	endfunction

	// busy covers both sampling and converting
	function automatic logic is_busy
	(
		input adc_ctl_pkg::conv_state_t s
	);
		is_busy = (s != adc_ctl_pkg::ST_IDLE);
	endfunction

	function automatic logic is_sampling
	(
		input adc_ctl_pkg::conv_state_t s
	);
		is_sampling = (s == adc_ctl_pkg::ST_SAMPLE);
	endfunction

	function automatic logic addr_ok
	(
		input logic [7:0] a
	);
		addr_ok = (a == adc_ctl_pkg::OFS_CTRL) ||
			(a == adc_ctl_pkg::OFS_DIV) ||
			(a == adc_ctl_pkg::OFS_STIME) ||
			(a == adc_ctl_pkg::OFS_STATUS);
	endfunction

	// read word for a mapped register, zero elsewhere and in upper bits
	function automatic logic [31:0] rd_word
	(
		input state_t     s,
		input logic [7:0] a
	);
		rd_word = adc_ctl_pkg::RD_ZERO;
		case (a)
			// the start bit reads as zero; status shows whether it took
			adc_ctl_pkg::OFS_CTRL:
				rd_word[adc_ctl_pkg::CTRL_REFSEL_BIT] = s.ref_sel;
			adc_ctl_pkg::OFS_DIV:
				rd_word[DIV_W-1:0] = s.div;
			adc_ctl_pkg::OFS_STIME:
				rd_word[STIME_W-1:0] = s.stime;
			adc_ctl_pkg::OFS_STATUS:
			begin
				rd_word[adc_ctl_pkg::STAT_BUSY_BIT] = is_busy(s.state);
				rd_word[adc_ctl_pkg::STAT_SAMPLE_BIT] =
					is_sampling(s.state);
				rd_word[adc_ctl_pkg::STAT_REFSEL_BIT] = s.ref_sel;
			end
			default:
				rd_word = adc_ctl_pkg::RD_ZERO;
		endcase
	endfunction

	logic access;
	logic wr;
	logic start_req;

	always_comb
	begin
		st_nxt = st_r;
		access = PSEL && PENABLE && !st_r.ready;
		wr = access && PWRITE;
		start_req = 1'b0;
		st_nxt.ready = access;
		st_nxt.slverr = access && !addr_ok(PADDR);
		st_nxt.done = 1'b0;
		st_nxt.rdata = adc_ctl_pkg::RD_ZERO;

		// a request is taken on its first access cycle and answered one
		// cycle later, so every transfer has exactly one wait state
		// register writes, all sampled on the system clock
		if (wr)
		begin
			case (PADDR)
				adc_ctl_pkg::OFS_CTRL:
				begin
					st_nxt.ref_sel =
						PWDATA[adc_ctl_pkg::CTRL_REFSEL_BIT];
					start_req = PWDATA[adc_ctl_pkg::CTRL_START_BIT];
				end
				adc_ctl_pkg::OFS_DIV:
					st_nxt.div = PWDATA[DIV_W-1:0];
				adc_ctl_pkg::OFS_STIME:
					st_nxt.stime = PWDATA[STIME_W-1:0];
				// status is read-only: a write there only answers
				adc_ctl_pkg::OFS_STATUS:
					start_req = 1'b0;
				default:
					start_req = 1'b0;
			endcase
		end

		// read data stands for the single ready cycle only
		if (access && !PWRITE)
			st_nxt.rdata = rd_word(st_r, PADDR);

		// internal converter clock as a one-cycle tick; kept private
		st_nxt.tick = 1'b0;
		if (st_r.state == adc_ctl_pkg::ST_IDLE)
			st_nxt.pre_cnt = '0;
		else if (st_r.pre_cnt >= div_top(st_r.run_div))
		begin
			st_nxt.pre_cnt = '0;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.pre_cnt = st_r.pre_cnt + adc_ctl_pkg::CNT_W'(1);

		case (st_r.state)
			adc_ctl_pkg::ST_IDLE:
			begin
				// start taken at this rising edge; starts while busy ignored
				if (start_req)
				begin
					st_nxt.state = adc_ctl_pkg::ST_SAMPLE;
					st_nxt.cyc_cnt = '0;
					// settings are frozen for the whole conversion so a
					// late write cannot stretch or cut one in flight
					st_nxt.run_div = st_r.div;
					st_nxt.run_stime = st_r.stime;
				end
			end
			adc_ctl_pkg::ST_SAMPLE:
			begin
				// sample length counts converter clocks, at least one
				if (st_r.tick)
				begin
					if (reached(st_r.cyc_cnt, st_r.run_stime))
					begin
						st_nxt.state = adc_ctl_pkg::ST_CONV;
						st_nxt.cyc_cnt = '0;
					end
					else
						st_nxt.cyc_cnt = cyc_step(st_r.cyc_cnt);
				end
			end
			adc_ctl_pkg::ST_CONV:
			begin
				if (st_r.tick)
				begin
					if (reached(st_r.cyc_cnt, conv_last))
					begin
						st_nxt.state = adc_ctl_pkg::ST_IDLE;
						st_nxt.done = 1'b1;
					end
					else
						st_nxt.cyc_cnt = cyc_step(st_r.cyc_cnt);
				end
			end
			default:
				st_nxt.state = adc_ctl_pkg::ST_IDLE;
		endcase

		// outputs are registered from the next state so each pin is a
		// flop and moves in the same cycle as the state it reports
		st_nxt.busy = is_busy(st_nxt.state);
		st_nxt.samp = is_sampling(st_nxt.state);
		st_nxt.ref_int = !st_nxt.ref_sel;
	end

	always_ff @(posedge SYS_CLK)
	begin
		// synchronous reset: internal reference, idle, bus quiet
		if (!RST_N)
		begin
			st_r.ref_sel <= 1'b0;
			st_r.div <= DIV_W'(adc_ctl_pkg::DIV_RST);
			st_r.stime <= STIME_W'(adc_ctl_pkg::STIME_RST);
			st_r.run_div <= DIV_W'(adc_ctl_pkg::DIV_RST);
			st_r.run_stime <= STIME_W'(adc_ctl_pkg::STIME_RST);
			st_r.pre_cnt <= '0;
			st_r.tick <= 1'b0;
			st_r.cyc_cnt <= '0;
			st_r.state <= adc_ctl_pkg::ST_IDLE;
			st_r.done <= 1'b0;
			st_r.rdata <= adc_ctl_pkg::RD_ZERO;
			st_r.ready <= 1'b0;
			st_r.slverr <= 1'b0;
			st_r.ref_int <= 1'b1;
			st_r.samp <= 1'b0;
			st_r.busy <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	// every output is a flop bit of the state register
	assign PRDATA = st_r.rdata;
	assign PREADY = st_r.ready;
	assign PSLVERR = st_r.slverr;
	assign REF_INTERNAL_EN = st_r.ref_int;
	assign SAMPLING = st_r.samp;
	assign BUSY = st_r.busy;
	assign CONV_DONE = st_r.done;
endmodule

// ==== tb/fabric_master.sv ====
// apb master standing in for the fabric user logic
`timescale 1ns/1ns
module fabric_master
(
	// bus
	input  wire logic        clk,
	input  wire logic        ready,
	input  wire logic        err,
	input  wire logic [31:0] rdata,
	output logic             sel,
	output logic             en,
	output logic             wr,
	output logic [7:0]       addr,
	output logic [31:0]      wdata
);
	initial {sel, en, wr, addr, wdata} = '0;
	// every change lands just after a system clock edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		sel <= 1'h1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		en <= 1'h1;
		do
			@(posedge clk);
		while (ready !== 1'h1);
		r = rdata;
		e = err;
		sel <= 1'h0;
		en <= 1'h0;
		// released data must not look valid
		wdata <= ~d;
	endtask
endmodule

// ==== tb/adc_ctl_props.sv ====
// port checks for the converter clock and start control
`timescale 1ns/1ns
module adc_ctl_props
(
	// all watched ports
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        REF_INTERNAL_EN,
	input wire logic        SAMPLING,
	input wire logic        BUSY,
	input wire logic        CONV_DONE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire tk = PSEL && PENABLE && !PREADY;
	wire wc = tk && PWRITE && PADDR == 8'h00;
	ready_wait_a: assert property (tk |=> PREADY)
		else $error("ready missing");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready too long");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("rdata outside access");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("slverr alone");
	start_take_a: assert property (wc && PWDATA[1] && !BUSY |=>
		BUSY && SAMPLING) else $error("start lost");
	ref_sel_a: assert property (wc |=>
		REF_INTERNAL_EN == !$past(PWDATA[0])) else $error("ref select");
	samp_busy_a: assert property (SAMPLING |-> BUSY)
		else $error("sampling while idle");
	done_end_a: assert property (CONV_DONE |->
		!BUSY && !SAMPLING && $past(BUSY)) else $error("done misplaced");
endmodule
bind adc_clock_and_start_control adc_ctl_props chk_u (.*);

// ==== tb/adc_clock_and_start_control_tb.sv ====
// self-checking bench for the converter clock and start control
`timescale 1ns/1ns
module adc_clock_and_start_control_tb;
	logic        clk = 0, rst_n = 0, sel, en, wr, ready, err, e;
	logic        ref_en, samp, busy, done;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, r;
	int          num_errors = 0, tests_run = 0, cyc = 0, sc, bc, dv, st, p;
	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		sc += (samp === 1'h1);
		bc += (busy === 1'h1);
		if (++cyc > 20000)
		begin
			num_errors++;
			end_of_test;
		end
	end
	adc_clock_and_start_control dut_u (.SYS_CLK(clk), .RST_N(rst_n),
		.PSEL(sel), .PENABLE(en), .PWRITE(wr), .PADDR(addr),
		.PWDATA(wdata), .PRDATA(rdata), .PREADY(ready), .PSLVERR(err),
		.REF_INTERNAL_EN(ref_en), .SAMPLING(samp), .BUSY(busy),
		.CONV_DONE(done));
	fabric_master pm_u (.*);
	task chk(input string s, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task end_of_test;
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		pm_u.xfer(1'h0, a, 32'h0, r, e);
		chk("rdata", r, x);
	endtask
	task wt(input logic [7:0] a, input int d);
		pm_u.xfer(1'h1, a, 32'(d), r, e);
	endtask
	initial
	begin
		void'($urandom(50265));
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		rd(adc_ctl_pkg::OFS_DIV, 32'h0);
		rd(adc_ctl_pkg::OFS_STIME, 32'h2);
		rd(8'h10, 32'h0);
		chk("slverr", e, 1'h1);
		for (int i = 0; i < 4; i++)
		begin
			dv = $urandom_range(0, 3);
			st = $urandom_range(0, 3);
			p = 4 * (dv + 1);
			wt(adc_ctl_pkg::OFS_DIV, dv);
			wt(adc_ctl_pkg::OFS_STIME, st);
			sc = 0;
			bc = 0;
			wt(adc_ctl_pkg::OFS_CTRL, 2 + i % 2);
			// a second start while busy must change nothing
			wt(adc_ctl_pkg::OFS_CTRL, 2 + i % 2);
			chk("ref", ref_en, i % 2 == 0);
			while (done !== 1'h1)
				@(posedge clk);
			chk("sample", sc >= st * p && sc <= (st + 1) * p + 1, 1);
			chk("busy", bc >= (st + 10) * p && bc <= (st + 11) * p + 2, 1);
			@(posedge clk);
			chk("idle", busy, 1'h0);
			chk("done", done, 1'h0);
			rd(adc_ctl_pkg::OFS_STATUS, (i % 2) * 4);
		end
		end_of_test;
	end
endmodule
